// [daa_regs_pkg.sv]
// Constants, register map and field layout of the control and status register bank.
// Assumes a 32-bit APB master with byte addresses, one aligned word per register.
package daa_regs_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam int unsigned        ADDR_W           = 8;
  localparam logic [3:0]         IDX_CONTROL_TWO  = 4'h6;
  localparam logic [3:0]         IDX_RSVD_SEVEN   = 4'h7;
  localparam logic [3:0]         IDX_RSVD_EIGHT   = 4'h8;
  localparam logic [3:0]         IDX_SAMPLE_RATE  = 4'h9;
  localparam logic [3:0]         IDX_RSVD_TEN     = 4'ha;
  localparam logic [3:0]         IDX_REVISION     = 4'hb;
  localparam logic [3:0]         IDX_LINE_STATUS  = 4'hc;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int unsigned        TX_LVL_HI_BIT    = 6;
  localparam int unsigned        TX_LVL_LO_BIT    = 1;
  localparam int unsigned        RX_LVL_HI_BIT    = 5;
  localparam int unsigned        RX_LVL_LO_BIT    = 0;
  localparam int unsigned        LINE_PD_BIT      = 4;
  localparam int unsigned        SYS_PD_BIT       = 3;
  localparam int unsigned        LINK_ERR_BIT     = 7;
  localparam int unsigned        FRAME_LOCK_BIT   = 6;

  // ****************************************************************
  // Reset values and writable masks.
  // ****************************************************************
  localparam logic [7:0]         CONTROL_TWO_RST  = 8'h70;
  localparam logic [7:0]         CONTROL_TWO_MASK = 8'h7b;
  localparam logic [2:0]         SAMPLE_RATE_RST  = 3'h0;
  localparam logic [3:0]         REVISION_DEFAULT = 4'h1;

  // ****************************************************************
  // Call-progress level codes and attenuation in dB.
  // ****************************************************************
  localparam logic [1:0]         LVL_CODE_MUTE    = 2'h2;
  localparam logic [5:0]         TX_ATTEN_DB_00   = 6'h1a;
  localparam logic [5:0]         TX_ATTEN_DB_01   = 6'h14;
  localparam logic [5:0]         TX_ATTEN_DB_11   = 6'h20;
  localparam logic [5:0]         RX_ATTEN_DB_00   = 6'h06;
  localparam logic [5:0]         RX_ATTEN_DB_01   = 6'h00;
  localparam logic [5:0]         RX_ATTEN_DB_11   = 6'h0c;

  // ****************************************************************
  // Sample rates in Hz; zero marks the reserved code.
  // ****************************************************************
  localparam logic [13:0]        RATE_HZ_0        = 14'h1c20;
  localparam logic [13:0]        RATE_HZ_1        = 14'h1f40;
  localparam logic [13:0]        RATE_HZ_2        = 14'h2025;
  localparam logic [13:0]        RATE_HZ_3        = 14'h20d0;
  localparam logic [13:0]        RATE_HZ_4        = 14'h2328;
  localparam logic [13:0]        RATE_HZ_5        = 14'h2580;
  localparam logic [13:0]        RATE_HZ_6        = 14'h282e;
  localparam logic [13:0]        RATE_HZ_RSVD     = 14'h0000;

  // ****************************************************************
  // Loop current exceptions.
  // ****************************************************************
  localparam logic [4:0]         SENSE_HIGH_EXC   = 5'h1e;
  localparam logic [3:0]         LOOP_HIGH_EXC    = 4'he;
  localparam logic [4:0]         SENSE_LOW_EXC    = 5'h01;
  localparam logic [3:0]         LOOP_LOW_EXC     = 4'h1;

endpackage

// [daa_control_status_regs.sv]
// Control and status register bank of the system-side line interface module.
// Assumes an APB master on sys_clk_in and link status inputs from logic on the same clock.
`timescale 1ns/1ps

module daa_control_status_regs #(
  parameter logic [3:0] REVISION = daa_regs_pkg::REVISION_DEFAULT  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic                                 sys_clk_in,
  input  wire logic                                 sys_rst_in,
  // APB slave.
  input  wire logic                                 psel_in,
  input  wire logic                                 penable_in,
  input  wire logic                                 pwrite_in,
  input  wire logic [daa_regs_pkg::ADDR_W-1:0]      paddr_in,
  input  wire logic [31:0]                          pwdata_in,
  input  wire logic [3:0]                           pstrb_in,
  output logic                                      pready_out,
  output logic [31:0]                               prdata_out,
  output logic                                      pslverr_out,
  // Line state from the link logic.
  input  wire logic                                 offhook_control_in,
  input  wire logic [4:0]                           line_sense_value_in,
  input  wire logic                                 link_error_event_in,
  input  wire logic                                 frame_lock_in,
  // Controls to the rest of the module.
  output logic [1:0]                                tx_callprog_level_out,
  output logic [1:0]                                rx_callprog_level_out,
  output logic                                      tx_callprog_mute_out,
  output logic                                      rx_callprog_mute_out,
  output logic [5:0]                                tx_callprog_atten_db_out,
  output logic [5:0]                                rx_callprog_atten_db_out,
  output logic                                      line_chip_powerdown_out,
  output logic                                      system_powerdown_out,
  output logic [2:0]                                sample_rate_select_out,
  output logic [13:0]                               sample_rate_hz_out,
  output logic [3:0]                                loop_current_field_out
);
  import daa_regs_pkg::*;

  // Output reset values follow the reset value of the control register.
  localparam logic [1:0] TX_LVL_RST = {CONTROL_TWO_RST[TX_LVL_HI_BIT], CONTROL_TWO_RST[TX_LVL_LO_BIT]};
  localparam logic [1:0] RX_LVL_RST = {CONTROL_TWO_RST[RX_LVL_HI_BIT], CONTROL_TWO_RST[RX_LVL_LO_BIT]};
  localparam logic [5:0] ATTEN_NONE = 6'h00;

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0]  control_two;
  logic [2:0]  sample_rate_select;
  logic        link_error;
  logic        frame_lock_flag;
  logic [3:0]  loop_current_field;
  logic        sys_pd_latched;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  wire         setup_phase   = psel_in & ~penable_in;
  wire         access_done   = psel_in & penable_in & pready_out;
  wire [3:0]   reg_index     = paddr_in[5:2];
  wire         addr_aligned  = (paddr_in[1:0] == 2'h0) & (paddr_in[ADDR_W-1:6] == '0);
  wire         hit_ctrl      = addr_aligned & (reg_index == IDX_CONTROL_TWO);
  wire         hit_rate      = addr_aligned & (reg_index == IDX_SAMPLE_RATE);
  wire         hit_rev       = addr_aligned & (reg_index == IDX_REVISION);
  wire         hit_status    = addr_aligned & (reg_index == IDX_LINE_STATUS);
  wire         hit_rsvd      = addr_aligned & ((reg_index == IDX_RSVD_SEVEN) |
                                               (reg_index == IDX_RSVD_EIGHT) |
                                               (reg_index == IDX_RSVD_TEN));
  wire         addr_mapped   = hit_ctrl | hit_rate | hit_rev | hit_status | hit_rsvd;
  wire         wr_low_lane   = access_done & pwrite_in & pstrb_in[0];
  wire         wr_ctrl       = wr_low_lane & hit_ctrl;
  wire         wr_rate       = wr_low_lane & hit_rate;
  wire         wr_status     = wr_low_lane & hit_status;

  // ****************************************************************
  // Read data mux; reserved bits and registers give zero.
  // ****************************************************************
  wire [7:0]   status_byte   = {link_error, frame_lock_flag, 2'h0, loop_current_field};
  wire [7:0]   read_byte     = hit_ctrl   ? control_two :
                               hit_rate   ? {5'h00, sample_rate_select} :
                               hit_rev    ? {4'h0, REVISION} :
                               hit_status ? status_byte : 8'h00;

  // ****************************************************************
  // Next values.
  // ****************************************************************
  wire [7:0]   next_control_two = (pwdata_in[7:0] & CONTROL_TWO_MASK);
  // A new error wins over a software clear in the same cycle.
  wire         next_link_error  = link_error_event_in |
                                  (link_error & ~(wr_status & ~pwdata_in[LINK_ERR_BIT]));

  // Loop current decode, exceptions only when off-hook.
  wire         offhook         = offhook_control_in;
  wire [3:0]   next_loop_current =
    (offhook & (line_sense_value_in == SENSE_HIGH_EXC)) ? LOOP_HIGH_EXC :
    (offhook & (line_sense_value_in == SENSE_LOW_EXC))  ? LOOP_LOW_EXC  :
    line_sense_value_in[4:1];

  // Level fields gathered from their split bit positions.
  wire [1:0]   tx_level = {control_two[TX_LVL_HI_BIT], control_two[TX_LVL_LO_BIT]};
  wire [1:0]   rx_level = {control_two[RX_LVL_HI_BIT], control_two[RX_LVL_LO_BIT]};

  logic [5:0]  next_tx_atten;
  logic [5:0]  next_rx_atten;
  logic [13:0] next_rate_hz;

  always_comb begin
    case (tx_level)
      2'h0:    next_tx_atten = TX_ATTEN_DB_00;
      2'h1:    next_tx_atten = TX_ATTEN_DB_01;
      2'h3:    next_tx_atten = TX_ATTEN_DB_11;
      default: next_tx_atten = 6'h00;
    endcase
    case (rx_level)
      2'h0:    next_rx_atten = RX_ATTEN_DB_00;
      2'h1:    next_rx_atten = RX_ATTEN_DB_01;
      2'h3:    next_rx_atten = RX_ATTEN_DB_11;
      default: next_rx_atten = 6'h00;
    endcase
    case (sample_rate_select)
      3'h0:    next_rate_hz = RATE_HZ_0;
      3'h1:    next_rate_hz = RATE_HZ_1;
      3'h2:    next_rate_hz = RATE_HZ_2;
      3'h3:    next_rate_hz = RATE_HZ_3;
      3'h4:    next_rate_hz = RATE_HZ_4;
      3'h5:    next_rate_hz = RATE_HZ_5;
      3'h6:    next_rate_hz = RATE_HZ_6;
      default: next_rate_hz = RATE_HZ_RSVD;
    endcase
  end

  // ****************************************************************
  // APB answer: one wait-free access phase after each setup cycle.
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= setup_phase;
      prdata_out  <= (setup_phase & ~pwrite_in) ? {24'h000000, read_byte} : 32'h0000_0000;
      pslverr_out <= setup_phase & ~addr_mapped;
    end
  end

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      control_two        <= CONTROL_TWO_RST;
      sample_rate_select <= SAMPLE_RATE_RST;
    end else begin
      if (wr_ctrl) begin
        control_two <= next_control_two;
      end
      if (wr_rate) begin
        sample_rate_select <= pwdata_in[2:0];
      end
    end
  end

  // ****************************************************************
  // Status registers.
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      link_error         <= 1'b0;
      frame_lock_flag    <= 1'b0;
      loop_current_field <= 4'h0;
    end else begin
      link_error         <= next_link_error;
      frame_lock_flag    <= frame_lock_in;
      loop_current_field <= next_loop_current;
    end
  end

  // ****************************************************************
  // Power-down: the system side stays down until reset, whatever the bit.
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sys_pd_latched <= 1'b0;
    end else if (control_two[SYS_PD_BIT]) begin
      sys_pd_latched <= 1'b1;
    end
  end

  // ****************************************************************
  // Registered outputs.
  // ****************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      // The reset code of both level fields mutes both paths.
      tx_callprog_level_out    <= TX_LVL_RST;
      rx_callprog_level_out    <= RX_LVL_RST;
      tx_callprog_mute_out     <= (TX_LVL_RST == LVL_CODE_MUTE);
      rx_callprog_mute_out     <= (RX_LVL_RST == LVL_CODE_MUTE);
      tx_callprog_atten_db_out <= ATTEN_NONE;
      rx_callprog_atten_db_out <= ATTEN_NONE;
      line_chip_powerdown_out  <= CONTROL_TWO_RST[LINE_PD_BIT];
      system_powerdown_out     <= CONTROL_TWO_RST[SYS_PD_BIT];
      sample_rate_select_out   <= SAMPLE_RATE_RST;
      sample_rate_hz_out       <= RATE_HZ_0;
      loop_current_field_out   <= 4'h0;
    end else begin
      tx_callprog_level_out    <= tx_level;
      rx_callprog_level_out    <= rx_level;
      tx_callprog_mute_out     <= (tx_level == LVL_CODE_MUTE);
      rx_callprog_mute_out     <= (rx_level == LVL_CODE_MUTE);
      tx_callprog_atten_db_out <= next_tx_atten;
      rx_callprog_atten_db_out <= next_rx_atten;
      line_chip_powerdown_out  <= control_two[LINE_PD_BIT];
      system_powerdown_out     <= sys_pd_latched | control_two[SYS_PD_BIT];
      sample_rate_select_out   <= sample_rate_select;
      sample_rate_hz_out       <= next_rate_hz;
      loop_current_field_out   <= loop_current_field;
    end
  end

endmodule

// [daa_regs_props.sv]
// Checker of the control and status register bank, watching only the bank's ports.
// Assumes one clock domain and is bound into every instance of the bank.
`timescale 1ns/1ps

module daa_regs_props (
  // Clock, reset and bus.
  input wire logic        sys_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [7:0]  paddr_in,
  input wire logic        pready_out,
  input wire logic [31:0] prdata_out,
  input wire logic        pslverr_out,
  // Line state.
  input wire logic        offhook_control_in,
  input wire logic [4:0]  line_sense_value_in,
  // Controls.
  input wire logic [1:0]  tx_callprog_level_out,
  input wire logic [1:0]  rx_callprog_level_out,
  input wire logic        tx_callprog_mute_out,
  input wire logic        rx_callprog_mute_out,
  input wire logic [5:0]  tx_callprog_atten_db_out,
  input wire logic [5:0]  rx_callprog_atten_db_out,
  input wire logic        line_chip_powerdown_out,
  input wire logic        system_powerdown_out,
  input wire logic [2:0]  sample_rate_select_out,
  input wire logic [13:0] sample_rate_hz_out,
  input wire logic [3:0]  loop_current_field_out
);
  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence setup_s;
    psel_in && !penable_in;
  endsequence
  bad_addr_a: assert property (setup_s and paddr_in[1:0] != 2'h0 |=> pready_out && pslverr_out && prdata_out == 0)
    else $error("misaligned access not refused");
  tx_mute_a: assert property (tx_callprog_level_out == 2'h2 |-> tx_callprog_mute_out)
    else $error("transmit mute code not muted");
  tx_atten_a: assert property (tx_callprog_level_out == 2'h3 |-> tx_callprog_atten_db_out == 6'h20)
    else $error("transmit attenuation wrong");
  rx_atten_a: assert property (rx_callprog_level_out == 2'h0 |-> rx_callprog_atten_db_out == 6'h06)
    else $error("receive attenuation wrong");
  tx_code_one_a: assert property (tx_callprog_level_out == 2'h1 |-> tx_callprog_atten_db_out == 6'h14 && !tx_callprog_mute_out)
    else $error("transmit code one wrong");
  rx_mute_a: assert property (rx_callprog_level_out == 2'h2 |-> rx_callprog_mute_out && rx_callprog_atten_db_out == 6'h00)
    else $error("receive mute code not muted");
  rx_code_three_a: assert property (rx_callprog_level_out == 2'h3 |-> rx_callprog_atten_db_out == 6'h0c && !rx_callprog_mute_out)
    else $error("receive code three wrong");
  sys_pd_a: assert property (system_powerdown_out |=> system_powerdown_out)
    else $error("system power-down left without reset");
  rate_a: assert property (sample_rate_select_out == 3'h0 |-> sample_rate_hz_out == 14'h1c20)
    else $error("rate code zero gives wrong rate");
  loop_on_a: assert property (!offhook_control_in |-> ##2 {loop_current_field_out, 1'b0} == ($past(line_sense_value_in, 2) & 5'h1e))
    else $error("on-hook loop current not the upper sense bits");
  loop_high_a: assert property (offhook_control_in && line_sense_value_in == 5'h1e |-> ##2 loop_current_field_out == 4'he)
    else $error("high sense exception missed");
  loop_low_a: assert property (offhook_control_in && line_sense_value_in == 5'h01 |-> ##2 loop_current_field_out == 4'h1)
    else $error("low sense exception missed");
  pd_reset_a: assert property ($fell(sys_rst_in) |-> line_chip_powerdown_out && !system_powerdown_out)
    else $error("power-down bits wrong after reset");
endmodule

bind daa_control_status_regs daa_regs_props i_daa_regs_props (.sys_clk_in, .sys_rst_in, .psel_in, .penable_in,
  .paddr_in, .pready_out, .prdata_out, .pslverr_out, .offhook_control_in, .line_sense_value_in,
  .tx_callprog_level_out, .rx_callprog_level_out, .tx_callprog_mute_out, .rx_callprog_mute_out,
  .tx_callprog_atten_db_out, .rx_callprog_atten_db_out, .line_chip_powerdown_out, .system_powerdown_out,
  .sample_rate_select_out, .sample_rate_hz_out, .loop_current_field_out);

// [line_side_model.sv]
// Behavioural model of the line-side device across the isolation link.
// Assumes the bench commands sense values and link faults on sys_clk_in.
`timescale 1ns/1ps

module line_side_model #(
  parameter int LOCK_CYCLES = 16
) (
  // Clock and commands.
  input  wire logic       sys_clk_in,
  input  wire logic       powerdown_in,
  input  wire logic [4:0] sense_set_in,
  input  wire logic       fault_in,
  // Link status.
  output logic [4:0]      line_sense_value_out = 5'h00,
  output logic            link_error_event_out = 1'b0,
  output logic            frame_lock_out = 1'b0
);
  int lock_count = 0;
  // A powered-down line chip loses lock and reports no sense value.
  always @(posedge sys_clk_in) begin
    if (powerdown_in) begin
      lock_count <= 0;
    end else if (lock_count < LOCK_CYCLES) begin
      lock_count <= lock_count + 1;
    end
    frame_lock_out <= !powerdown_in && lock_count == LOCK_CYCLES;
    line_sense_value_out <= powerdown_in ? 5'h00 : sense_set_in;
    link_error_event_out <= fault_in;
  end
endmodule

// [daa_control_status_regs_tb_top.sv]
// Self-checking bench of the control and status register bank.
// Assumes the package, the design, the checker and the line-side model compile first.
`timescale 1ns/1ps

module daa_control_status_regs_tb_top;
  import daa_regs_pkg::*;
  localparam logic [3:0] REV = 4'h5; // Arbitrary value.
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, offhook = 1'b0, fault = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r = 32'h10170739;
  logic [4:0]  sense_set = 5'h00, sense;
  logic        pready, pslverr, line_pd, sys_pd, lerr, lock;
  logic [13:0] rate_hz;
  logic [3:0]  loop;
  logic [1:0]  tx_lvl, rx_lvl, tc, rc;
  logic        tx_mute, rx_mute;
  logic [5:0]  tx_att, rx_att;
  logic [2:0]  rate_sel;
  logic [5:0]  tx_att_tab[4] = '{6'h1a, 6'h14, 6'h00, 6'h20};
  logic [5:0]  rx_att_tab[4] = '{6'h06, 6'h00, 6'h00, 6'h0c};
  logic [32:0] exp_q[$];
  int          errors = 0, num_checks = 0, cycles = 0;
  logic [7:0]  rd_addr[7] = '{8'h1c, 8'h20, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h19};
  logic [32:0] rd_exp[7] = '{33'h0, 33'h0, 33'h0, {29'h0, REV}, 33'h0, 33'h100000000, 33'h100000000};
  logic [13:0] rate_tab[8] = '{14'h1c20, 14'h1f40, 14'h2025, 14'h20d0, 14'h2328, 14'h2580, 14'h282e, 14'h0000};
  logic        hook_tab[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [4:0]  sv_tab[5] = '{5'h1e, 5'h01, 5'h1e, 5'h01, 5'h14};
  logic [3:0]  lc_tab[5] = '{4'he, 4'h1, 4'hf, 4'h0, 4'ha};

  always #2.5 sys_clk_in = ~sys_clk_in;

  daa_control_status_regs #(.REVISION(REV)) i_daa_control_status_regs (.sys_clk_in, .sys_rst_in, .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .offhook_control_in(offhook),
    .line_sense_value_in(sense), .link_error_event_in(lerr), .frame_lock_in(lock), .tx_callprog_level_out(tx_lvl),
    .rx_callprog_level_out(rx_lvl), .tx_callprog_mute_out(tx_mute), .rx_callprog_mute_out(rx_mute),
    .tx_callprog_atten_db_out(tx_att), .rx_callprog_atten_db_out(rx_att), .line_chip_powerdown_out(line_pd),
    .system_powerdown_out(sys_pd), .sample_rate_select_out(rate_sel), .sample_rate_hz_out(rate_hz),
    .loop_current_field_out(loop));
  line_side_model #(.LOCK_CYCLES(16)) i_line_side_model (.sys_clk_in, .powerdown_in(line_pd),
    .sense_set_in(sense_set), .fault_in(fault), .line_sense_value_out(sense), .link_error_event_out(lerr),
    .frame_lock_out(lock));

  // ****************************************************************
  // Bus tasks, comparison and verdict.
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      exp_q.push_back(e);
    end
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do @(posedge sys_clk_in); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic reset_dut();
    sys_rst_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Every read answer is compared with the oldest expectation noted by the driver.
  always @(posedge sys_clk_in) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    reset_dut();
    xfer(1'b0, 8'h18, 32'h0, 33'h70);
    xfer(1'b0, 8'h24, 32'h0, 33'h0);
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, rd_addr[i], 32'hff, 33'h0);
      xfer(1'b0, rd_addr[i], 32'h0, rd_exp[i]);
    end
    for (int c = 0; c < 8; c++) begin
      r = lfsr(r);
      xfer(1'b1, 8'h24, {r[31:3], 3'(c)}, 33'h0);
      repeat (2) @(posedge sys_clk_in);
      check(33'({rate_sel, rate_hz}), 33'({3'(c), rate_tab[c]}));
      xfer(1'b0, 8'h24, 32'h0, 33'(c));
    end
    for (int i = 0; i < 6; i++) begin
      r = lfsr(lfsr(r));
      tc = {r[6], r[1]};
      rc = {r[5], r[0]};
      xfer(1'b1, 8'h18, r, 33'h0);
      xfer(1'b0, 8'h18, 32'h0, 33'(r[7:0] & 8'h7b));
      check(33'({tx_lvl, rx_lvl, tx_mute, rx_mute}), 33'({tc, rc, tc == 2'h2, rc == 2'h2}));
      check(33'({tx_att, rx_att}), 33'({tx_att_tab[tc], rx_att_tab[rc]}));
    end
    xfer(1'b1, 8'h18, 32'h03, 33'h0);
    xfer(1'b1, 8'h18, 32'h7b, 33'h0);
    xfer(1'b1, 8'h18, 32'h0, 33'h0);
    repeat (24) @(posedge sys_clk_in);
    for (int i = 0; i < 5; i++) begin
      offhook <= hook_tab[i];
      sense_set <= sv_tab[i];
      repeat (4) @(posedge sys_clk_in);
      xfer(1'b0, 8'h30, 32'h0, {25'h0, 4'h4, lc_tab[i]});
      check(33'(loop), 33'(lc_tab[i]));
    end
    fault <= 1'b1;
    @(posedge sys_clk_in);
    fault <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    xfer(1'b0, 8'h30, 32'h0, 33'hca);
    xfer(1'b1, 8'h30, 32'hff, 33'h0);
    xfer(1'b0, 8'h30, 32'h0, 33'hca);
    xfer(1'b1, 8'h30, 32'h0, 33'h0);
    xfer(1'b0, 8'h30, 32'h0, 33'h4a);
    reset_dut();
    check(33'({sys_pd, line_pd}), 33'h1);
    xfer(1'b1, 8'h18, 32'h08, 33'h0);
    xfer(1'b1, 8'h18, 32'h00, 33'h0);
    xfer(1'b0, 8'h18, 32'h0, 33'h0);
    check(33'(sys_pd), 33'h1);
    test_done();
  end
endmodule
